// ==== rtl/card_pkg.sv ====
// card_pkg: shared constants and types of the card reader controller
// assumes: 10 MHz system clock, 12-bit accumulator words
package card_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int COL_WINDOW_NS   = 1000000;
  localparam int COL_WINDOW_CYC  = COL_WINDOW_NS / CLK_PERIOD_NS;
  localparam int PICK_TIMEOUT_NS = 100000000;
  localparam int PICK_TIMEOUT_CYC = PICK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CARD_COLUMNS    = 40;

  // ----------------------------------------------------------------
  // instruction codes on the command port (low digit, device bit)
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SKIP_COL_READY = 4'h1;
  localparam logic [3:0] OP_READ_ALPHA     = 4'h2;
  localparam logic [3:0] OP_READ_BINARY    = 4'h4;
  localparam logic [3:0] OP_COND_OUT       = 4'h5;
  localparam logic [3:0] OP_READ_COMP      = 4'h6;
  localparam logic [3:0] OP_COND_IN        = 4'h7;
  localparam logic [3:0] OP_SKIP_CARD_DONE = 4'h9;
  localparam logic [3:0] OP_SELECT_SKIP    = 4'hA;
  localparam logic [3:0] OP_CLR_CARD_DONE  = 4'hC;
  localparam logic [3:0] OP_SKIP_INT       = 4'hD;
  localparam logic [3:0] OP_CLR_TRANS      = 4'hF;

  // ----------------------------------------------------------------
  // field positions (bit 11 is accumulator bit 0)
  // ----------------------------------------------------------------
  localparam int AC_SIGN        = 11;
  localparam int EN_TRANS_BIT   = 1;
  localparam int EN_DATA_BIT    = 0;
  localparam int ST_DATA_READY  = 11;
  localparam int ST_CARD_DONE   = 10;
  localparam int ST_TROUBLE     = 9;
  localparam int ST_READY_TRUE  = 8;
  localparam int ST_DATA_LOST   = 7;
  localparam logic EN_TRANS_RESET = 1'b0;
  localparam logic EN_DATA_RESET  = 1'b1;

  typedef enum logic [1:0] {
    RD_BINARY = 2'b00,
    RD_ALPHA  = 2'b01,
    RD_COMP   = 2'b10
  } read_form_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PICK = 2'b01,
    ST_READ = 2'b10
  } transport_state_t;

  // answer to a read strobe
  typedef struct packed {
    logic        skip;
    logic [11:0] ac;
  } iot_answer_t;

  // transport pins after synchronising
  typedef struct packed {
    logic [11:0] rows;
    logic        col_strobe;
    logic        card_in_station;
    logic        torn_edge;
    logic        hopper_empty;
    logic        stacker_full;
    logic        halt_button;
    logic        reset_button;
    logic        mode_online;
  } reader_pins_t;

endpackage : card_pkg

// ==== rtl/pin_sync.sv ====
// pin_sync: two flip-flop synchroniser for a bundle of pins
// assumes: all inputs asynchronous to clk_sys
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // pins
  input  wire logic [WIDTH-1:0] pins_async,
  output logic      [WIDTH-1:0] pins_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1    <= '0;
      pins_sync <= '0;
    end else begin
      stage1    <= pins_async;
      pins_sync <= stage1;
    end
  end
endmodule : pin_sync

// ==== rtl/column_decoder.sv ====
// column_decoder: turns one column of twelve rows into an accumulator word
// assumes: rows[11] is row 12, rows[10] row 11, rows[9] row 0,
// rows[8:0] rows 1..9; a hole or dark mark reads as one
`timescale 1ns/100ps
module column_decoder (
  // column and form
  input  wire logic [11:0]         rows,
  input  card_pkg::read_form_t     form,
  // result
  output logic      [11:0]         ac
);
  // ----------------------------------------------------------------
  // digit rows 1..7 to binary, plus multi-punch detect
  // ----------------------------------------------------------------
  function automatic logic [3:0] digit_code(input logic [6:0] d);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 7; i++) begin
      if (d[6-i]) begin
        r[2:0] = 3'(i + 1);
      end
    end
    r[3] = ($countones(d) > 1);
    return r;
  endfunction : digit_code

  logic [3:0] dig;
  logic [3:0] num;
  logic [1:0] zone;

  always_comb begin
    dig  = digit_code(rows[8:2]);
    num  = {1'b0, dig[2:0]};
    zone = 2'b00;
    if (rows[1]) begin
      num = num + 4'h8;
    end
    if (rows[0]) begin
      num = 4'h9;
    end
    if (rows[11]) begin
      zone = 2'b11;
    end else if (rows[10]) begin
      zone = 2'b10;
    end else if (rows[9] && num != 4'h0) begin
      zone = 2'b01;
    end else if (rows[9]) begin
      num = 4'hA;
    end
    case (form)
      card_pkg::RD_BINARY: ac = rows;                    // R4 R9 R10
      card_pkg::RD_ALPHA:  ac = {6'h00, zone, num};      // R5 R9
      card_pkg::RD_COMP: begin
        ac = {dig[3], 3'h0, rows[0], rows[11], rows[10],
              rows[9], rows[1], dig[2:0]};               // R6 R7 R8
      end
      default: ac = 12'h000;
    endcase
  end
endmodule : column_decoder

// ==== rtl/card_reader_control.sv ====
// card_reader_control: card reader controller with its reader transport
// assumes: commands arrive as one-cycle strobes on the command port and
// transport pins are asynchronous to clk_sys
//
// Summary of operation
// R1: skip when an enabled flag is raised
// R2: clear both transition flags, nothing else
// R3: present forty columns from column one
// R4: binary form maps rows straight to bits
// R5: alphanumeric form gives six-bit code low
// R6: compressed copies rows 9,12,11,0,8
// R7: compressed encodes single digit punch binary
// R8: double digit punch sets sign bit
// R9: validity check only on compressed read
// R10: hole or dark mark reads as one
// R11: both card variants share identical instructions
// R12: software may compare reads within window
// R13: halt drops feed and ready, finishes card
// R14: read check condition stops the reader
// R15: stack check when card never arrives
// R16: hopper check on empty hopper, full stacker
// R17: offline ignores feed request, outputs stay
// R18: reset button clears errors and counters
// R19: host selects, polls, reads, polls done
// R20: column ready sets data ready flag
// R21: card leaving sets card done flag
// R22: ready edges set transition flags
// R23: select skips, feeds card, clears done
// R24: column held until next column arrives
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module card_reader_control #(
  parameter int COL_WINDOW_CYC   = card_pkg::COL_WINDOW_CYC,
  parameter int PICK_TIMEOUT_CYC = card_pkg::PICK_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // command port
  input  wire logic [3:0]           cmd_addr,
  input  wire logic [11:0]          cmd_wdata,
  input  wire logic                 cmd_wr,
  input  wire logic                 cmd_rd,
  output card_pkg::iot_answer_t     cmd_rdata,
  // transport pins
  input  card_pkg::reader_pins_t    reader_pins,
  output logic                      card_feed_request,
  output logic                      reader_ready,
  // alarms and indicators
  output logic                      read_check,
  output logic                      stack_check,
  output logic                      hopper_check,
  output logic                      halt_lamp,
  output logic                      int_request
);
  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;
  card_pkg::reader_pins_t pins;
  card_pkg::reader_pins_t pins_d;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  pin_sync #(.WIDTH($bits(card_pkg::reader_pins_t))) u_sync (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pins_async (reader_pins),
    .pins_sync  (pins)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_d <= '0;
    end else begin
      pins_d <= pins;
    end
  end

  logic strobe_rise;
  logic card_arrive;
  logic card_leave;
  assign strobe_rise = pins.col_strobe & ~pins_d.col_strobe;
  assign card_arrive = pins.card_in_station & ~pins_d.card_in_station;
  assign card_leave  = ~pins.card_in_station & pins_d.card_in_station;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic is_op(input logic [3:0] a,
                                 input logic [3:0] op);
    return a == op;
  endfunction : is_op

  logic do_select;
  logic do_read;
  logic col_taken;
  assign do_select = cmd_rd & is_op(cmd_addr, card_pkg::OP_SELECT_SKIP);
  assign do_read   = cmd_rd & (is_op(cmd_addr, card_pkg::OP_READ_ALPHA)
                   | is_op(cmd_addr, card_pkg::OP_READ_BINARY)
                   | is_op(cmd_addr, card_pkg::OP_READ_COMP));

  // ----------------------------------------------------------------
  // transport
  // ----------------------------------------------------------------
  card_pkg::transport_state_t state;
  card_pkg::transport_state_t next_state;
  logic [5:0]  col_count;
  logic [5:0]  next_col_count;
  logic [31:0] pick_timer;
  logic [31:0] next_pick_timer;
  logic        halt;
  logic        next_halt;
  logic        next_read_check;
  logic        next_stack_check;
  logic        next_hopper_check;

  assign reader_ready = pins.mode_online & ~halt & ~pins.halt_button
                      & ~read_check & ~stack_check & ~hopper_check;
  assign card_feed_request = (state == card_pkg::ST_PICK)
                           & pins.mode_online & ~halt
                           & ~pins.halt_button;           // R13 R17
  assign halt_lamp = halt;

  always_comb begin
    next_state        = state;
    next_col_count    = col_count;
    next_pick_timer   = pick_timer;
    next_halt         = halt | pins.halt_button;          // R13
    next_read_check   = read_check;
    next_stack_check  = stack_check;
    next_hopper_check = hopper_check
                      | pins.hopper_empty | pins.stacker_full; // R16
    col_taken         = 1'b0;
    case (state)
      card_pkg::ST_IDLE: begin
        next_pick_timer = 32'h0000_0000;
        if (do_select && reader_ready) begin
          next_state = card_pkg::ST_PICK;                 // R23
        end
      end
      card_pkg::ST_PICK: begin
        if (card_arrive) begin
          next_state     = card_pkg::ST_READ;
          next_col_count = 6'h00;                         // R3
        end else if (!card_feed_request) begin
          next_state = card_pkg::ST_IDLE;                 // R13 R17
        end else if (pick_timer == 32'(PICK_TIMEOUT_CYC - 1)) begin
          next_stack_check = 1'b1;                        // R15
          next_state       = card_pkg::ST_IDLE;
        end else begin
          next_pick_timer = pick_timer + 32'h0000_0001;
        end
      end
      card_pkg::ST_READ: begin
        if (pins.torn_edge) begin
          next_read_check = 1'b1;                         // R14
        end
        if (strobe_rise) begin
          if (col_count == 6'(card_pkg::CARD_COLUMNS)) begin
            next_read_check = next_read_check
                            | (pins.rows != 12'h000);     // R14
          end else begin
            col_taken      = 1'b1;                        // R3
            next_col_count = col_count + 6'h01;
          end
        end
        if (card_leave) begin
          next_state = card_pkg::ST_IDLE;                 // R13 R21
        end
      end
      default: next_state = card_pkg::ST_IDLE;
    endcase
    if (pins.reset_button) begin
      next_state        = card_pkg::ST_IDLE;              // R18
      next_col_count    = 6'h00;
      next_pick_timer   = 32'h0000_0000;
      next_halt         = 1'b0;
      next_read_check   = 1'b0;
      next_stack_check  = 1'b0;
      next_hopper_check = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state        <= card_pkg::ST_IDLE;
      col_count    <= 6'h00;
      pick_timer   <= 32'h0000_0000;
      halt         <= 1'b0;
      read_check   <= 1'b0;
      stack_check  <= 1'b0;
      hopper_check <= 1'b0;
    end else begin
      state        <= next_state;
      col_count    <= next_col_count;
      pick_timer   <= next_pick_timer;
      halt         <= next_halt;
      read_check   <= next_read_check;
      stack_check  <= next_stack_check;
      hopper_check <= next_hopper_check;
    end
  end

  // ----------------------------------------------------------------
  // flags, enables, column buffer and answers
  // ----------------------------------------------------------------
  logic        data_ready;
  logic        card_done;
  logic        trouble;
  logic        ready_true;
  logic        data_lost;
  logic        en_trans;
  logic        en_data;
  logic        ready_q;
  logic [11:0] col_buf;
  logic [31:0] win_cnt;
  logic        next_data_ready;
  logic        next_card_done;
  logic        next_trouble;
  logic        next_ready_true;
  logic        next_data_lost;
  logic        next_en_trans;
  logic        next_en_data;
  logic [11:0] next_col_buf;
  logic [31:0] next_win_cnt;
  card_pkg::iot_answer_t next_rdata;
  card_pkg::read_form_t  form;
  logic [11:0] decoded;
  logic        int_skip;

  always_comb begin
    case (cmd_addr)
      card_pkg::OP_READ_ALPHA: form = card_pkg::RD_ALPHA;
      card_pkg::OP_READ_COMP:  form = card_pkg::RD_COMP;
      default:                 form = card_pkg::RD_BINARY;
    endcase
  end

  column_decoder u_dec (
    .rows (col_buf),
    .form (form),
    .ac   (decoded)
  );

  assign int_skip = ((data_ready | card_done) & en_data)
                  | ((trouble | ready_true) & en_trans);  // R1 R11
  assign int_request = int_skip;

  always_comb begin
    next_col_buf    = col_taken ? pins.rows : col_buf;     // R24
    next_win_cnt    = win_cnt;
    next_data_ready = data_ready;
    next_data_lost  = data_lost;
    next_card_done  = card_done;
    next_trouble    = trouble;
    next_ready_true = ready_true;
    next_en_trans   = en_trans;
    next_en_data    = en_data;
    next_rdata      = '0;
    if (cmd_wr && is_op(cmd_addr, card_pkg::OP_COND_OUT)) begin
      next_en_trans = cmd_wdata[card_pkg::EN_TRANS_BIT];
      next_en_data  = cmd_wdata[card_pkg::EN_DATA_BIT];
      next_data_lost = 1'b0;
    end
    // a window running out wins over a clear in the same cycle
    if (data_ready && win_cnt == 32'(COL_WINDOW_CYC - 1)) begin
      next_data_lost = 1'b1;                              // R20
    end else if (data_ready) begin
      next_win_cnt = win_cnt + 32'h0000_0001;
    end
    if (cmd_wr && is_op(cmd_addr, card_pkg::OP_CLR_TRANS)) begin
      next_trouble    = 1'b0;                             // R2
      next_ready_true = 1'b0;                             // R2
    end
    if (cmd_wr && is_op(cmd_addr, card_pkg::OP_CLR_CARD_DONE)) begin
      next_card_done = 1'b0;
    end
    if (do_read) begin
      next_data_ready = 1'b0;
      next_rdata.ac   = decoded;                          // R4 R5 R6 R7
    end
    if (cmd_rd) begin
      case (cmd_addr)
        card_pkg::OP_SKIP_COL_READY: next_rdata.skip = data_ready;
        card_pkg::OP_SKIP_CARD_DONE: next_rdata.skip = card_done;
        card_pkg::OP_SKIP_INT:       next_rdata.skip = int_skip; // R1
        card_pkg::OP_SELECT_SKIP: begin
          next_rdata.skip = reader_ready;                 // R23
          if (reader_ready) begin
            next_card_done = 1'b0;                        // R23
          end
        end
        card_pkg::OP_COND_IN: begin
          next_rdata.ac[card_pkg::ST_DATA_READY] = data_ready;
          next_rdata.ac[card_pkg::ST_CARD_DONE]  = card_done;
          next_rdata.ac[card_pkg::ST_TROUBLE]    = trouble;
          next_rdata.ac[card_pkg::ST_READY_TRUE] = ready_true;
          next_rdata.ac[card_pkg::ST_DATA_LOST]  = data_lost;
        end
        default: next_rdata.skip = 1'b0;
      endcase
    end
    // hardware events win over a clear in the same cycle
    if (col_taken) begin
      next_data_ready = 1'b1;                             // R20
      next_win_cnt    = 32'h0000_0000;
    end
    if (state == card_pkg::ST_READ && card_leave) begin
      next_card_done = 1'b1;                              // R21
    end
    if (reader_ready && !ready_q) begin
      next_ready_true = 1'b1;                             // R22
    end
    if (!reader_ready && ready_q) begin
      next_trouble = 1'b1;                                // R22
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_ready <= 1'b0;
      card_done  <= 1'b0;
      trouble    <= 1'b0;
      ready_true <= 1'b0;
      data_lost  <= 1'b0;
      en_trans   <= card_pkg::EN_TRANS_RESET;
      en_data    <= card_pkg::EN_DATA_RESET;
      ready_q    <= 1'b0;
      col_buf    <= 12'h000;
      win_cnt    <= 32'h0000_0000;
      cmd_rdata  <= '0;
    end else begin
      data_ready <= next_data_ready;
      card_done  <= next_card_done;
      trouble    <= next_trouble;
      ready_true <= next_ready_true;
      data_lost  <= next_data_lost;
      en_trans   <= next_en_trans;
      en_data    <= next_en_data;
      ready_q    <= reader_ready;
      col_buf    <= next_col_buf;
      win_cnt    <= next_win_cnt;
      cmd_rdata  <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_halt_press;
    pins.halt_button ##1 1'b1;
  endsequence

  a_skip_int_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_rd && cmd_addr == card_pkg::OP_SKIP_INT
    |=> cmd_rdata.skip == $past(int_skip))                   // R1
    else $error("interrupt skip answer wrong");
  a_clr_trans_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_wr && cmd_addr == card_pkg::OP_CLR_TRANS && reader_ready == ready_q
    && !col_taken && !card_leave
    |=> !trouble && !ready_true && card_done == $past(card_done)
    && data_ready == $past(data_ready))                      // R2
    else $error("transition clear wrong");
  a_first_column: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == card_pkg::ST_PICK && card_arrive && !pins.reset_button
    |=> state == card_pkg::ST_READ && col_count == 6'h00)   // R3
    else $error("card did not start at column one");
  a_binary_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_rd && cmd_addr == card_pkg::OP_READ_BINARY
    |=> cmd_rdata.ac == $past(col_buf) && !data_ready || $past(col_taken))// R4
    else $error("binary read mismatch");
  a_comp_sign_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_rd && cmd_addr == card_pkg::OP_READ_COMP
    |=> cmd_rdata.ac[card_pkg::AC_SIGN]
        == ($countones($past(col_buf[8:2])) > 1))           // R8
    else $error("compressed validity bit wrong");
  a_halt_drops_feed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_halt_press |-> !card_feed_request && !reader_ready)    // R13
    else $error("halt did not drop feed and ready");
  a_offline_no_feed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pins.mode_online |-> !card_feed_request)                // R17
    else $error("feed request while offline");
  a_stack_timeout: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == card_pkg::ST_PICK && card_feed_request && !card_arrive
    && !pins.reset_button && pick_timer == 32'(PICK_TIMEOUT_CYC - 1)
    |=> stack_check && state == card_pkg::ST_IDLE)           // R15
    else $error("stack check not raised");
  a_reset_button: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pins.reset_button |=> !read_check && !stack_check
    && col_count == 6'h00 && state == card_pkg::ST_IDLE)     // R18
    else $error("reset button left state");
  a_ready_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(reader_ready) |=> ready_true)                      // R22
    else $error("ready edge flag missing");
endmodule : card_reader_control

// ==== bench/card_transport_model.sv ====
// card_transport_model: card transport at the controller's pins
// assumes: one card per feed request unless jam holds it back,
// all columns carry col_rows
`timescale 1ns/100ps
module card_transport_model (
  // clock
  input  wire logic             clk_sys,
  // controls from bench and controller
  input  wire logic             card_feed_request,
  input  wire logic [11:0]      col_rows,
  input  wire logic             mode_online,
  input  wire logic             hopper_empty,
  input  wire logic             reset_button,
  input  wire logic             halt_button,
  input  wire logic             jam,
  // pins
  output card_pkg::reader_pins_t reader_pins
);
  logic [11:0] rows = 12'hFFF;
  logic        strobe = 1'b0;
  logic        in_station = 1'b0;
  int          c;
  assign reader_pins = '{rows: rows, col_strobe: strobe,
    card_in_station: in_station, torn_edge: 1'b0,
    hopper_empty: hopper_empty, stacker_full: 1'b0, halt_button: halt_button,
    reset_button: reset_button, mode_online: mode_online};
  // rows show the inverse of the column outside the strobe window
  initial begin
    forever begin
      @(posedge clk_sys);
      if (card_feed_request && !jam) begin
        repeat (5) @(posedge clk_sys);
        in_station <= 1'b1;
        for (c = 0; c < card_pkg::CARD_COLUMNS; c++) begin
          repeat (30) @(posedge clk_sys);
          rows <= col_rows;
          repeat (3) @(posedge clk_sys);
          strobe <= 1'b1;
          repeat (4) @(posedge clk_sys);
          strobe <= 1'b0;
          repeat (3) @(posedge clk_sys);
          rows <= ~col_rows;
          repeat (20) @(posedge clk_sys);
        end
        in_station <= 1'b0;
      end
    end
  end
endmodule : card_transport_model

// ==== bench/tb_card_reader_control.sv ====
// tb_card_reader_control: self-checking bench of the controller
// assumes: card_transport_model drives the transport pins
`timescale 1ns/100ps
module tb_card_reader_control;
  logic                  clk_sys   = 1'b0;
  logic                  reset_n   = 1'b0;
  logic [3:0]            cmd_addr  = 4'h0;
  logic [11:0]           cmd_wdata = 12'h000;
  logic                  cmd_wr    = 1'b0;
  logic                  cmd_rd    = 1'b0;
  logic [11:0]           col_rows  = 12'h000;
  logic                  online    = 1'b1;
  logic                  hop       = 1'b0;
  logic                  rst_btn   = 1'b0;
  logic                  hlt       = 1'b0;
  logic                  jam       = 1'b0;
  card_pkg::iot_answer_t cmd_rdata;
  card_pkg::iot_answer_t a;
  card_pkg::reader_pins_t reader_pins;
  logic                  feed;
  logic                  rdy;
  logic                  hchk;
  logic                  irq;
  logic                  stk;
  logic                  rchk;
  logic                  lamp;
  int                    errors = 0;
  int                    comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  card_reader_control #(.COL_WINDOW_CYC(200), .PICK_TIMEOUT_CYC(50))
    u_card_reader_control (.clk_sys(clk_sys), .reset_n(reset_n),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .reader_pins(reader_pins),
    .card_feed_request(feed), .reader_ready(rdy), .read_check(rchk),
    .stack_check(stk), .hopper_check(hchk), .halt_lamp(lamp),
    .int_request(irq));
  card_transport_model u_card_transport_model (.clk_sys(clk_sys),
    .card_feed_request(feed), .col_rows(col_rows), .mode_online(online),
    .hopper_empty(hop), .reset_button(rst_btn), .halt_button(hlt),
    .jam(jam), .reader_pins(reader_pins));
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk12(input logic [11:0] got, exp, msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk12
  task automatic chk1(input logic got, exp);
    chk12({11'h000, got}, {11'h000, exp}, 12'h001);
  endtask : chk1
  task automatic rd(input logic [3:0] op);
    @(posedge clk_sys);
    cmd_addr <= op;
    cmd_rd <= 1'b1;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    #1 a = cmd_rdata;
  endtask : rd
  task automatic wr(input logic [3:0] op, input logic [11:0] d);
    @(posedge clk_sys);
    cmd_addr <= op;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
  endtask : wr
  task automatic t_flags;
    rd(card_pkg::OP_COND_IN);
    chk12(a.ac, 12'h100, 12'hF00);
    wr(card_pkg::OP_CLR_TRANS, 12'h000);
    rd(card_pkg::OP_COND_IN);
    chk12(a.ac, 12'h000, 12'h300);
    rd(card_pkg::OP_SKIP_INT);
    chk1(a.skip, 1'b0);
    wr(card_pkg::OP_COND_OUT, 12'h003);
    online <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(card_pkg::OP_SKIP_INT);
    chk1(a.skip, 1'b1);
    chk1(irq, 1'b1);
    rd(card_pkg::OP_COND_IN);
    chk12(a.ac, 12'h200, 12'h300);
    rd(card_pkg::OP_SELECT_SKIP);
    chk1(a.skip, 1'b0);
    chk1(feed, 1'b0);
    @(posedge clk_sys);
    online <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(card_pkg::OP_COND_IN);
    chk12(a.ac, 12'h100, 12'h100);
  endtask : t_flags
  task automatic t_hopper;
    @(posedge clk_sys);
    jam <= 1'b1;
    rd(card_pkg::OP_SELECT_SKIP);
    chk1(a.skip, 1'b1);
    chk1(feed, 1'b1);
    repeat (60) @(posedge clk_sys);
    chk1(stk, 1'b1);
    jam <= 1'b0;
    hop <= 1'b1;
    hlt <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk1(hchk, 1'b1);
    chk1(lamp, 1'b1);
    chk1(rdy, 1'b0);
    hop <= 1'b0;
    hlt <= 1'b0;
    rst_btn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_btn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk1(hchk, 1'b0);
    chk1(stk, 1'b0);
    chk1(lamp, 1'b0);
    chk1(rdy, 1'b1);
  endtask : t_hopper
  task automatic t_card(input logic [11:0] r, al, am, cp, cm);
    int n;
    int k;
    @(posedge clk_sys);
    col_rows <= r;
    rd(card_pkg::OP_SELECT_SKIP);
    chk1(a.skip, 1'b1);
    rd(card_pkg::OP_SKIP_CARD_DONE);
    chk1(a.skip, 1'b0);
    for (n = 0; n < card_pkg::CARD_COLUMNS; n++) begin
      k = 0;
      do begin
        rd(card_pkg::OP_SKIP_COL_READY);
        k++;
      end while (a.skip !== 1'b1 && k < 200);
      if (k >= 200) begin
        errors++;
        end_of_test();
      end
      rd(card_pkg::OP_READ_BINARY);
      chk12(a.ac, r, 12'hFFF);
      rd(card_pkg::OP_READ_ALPHA);
      chk12(a.ac, al, am);
      rd(card_pkg::OP_READ_COMP);
      chk12(a.ac, cp, cm);
      rd(card_pkg::OP_READ_BINARY);
      chk12(a.ac, r, 12'hFFF);
    end
    k = 0;
    do begin
      rd(card_pkg::OP_SKIP_CARD_DONE);
      k++;
    end while (a.skip !== 1'b1 && k < 400);
    chk1(a.skip, 1'b1);
    if (a.skip !== 1'b1) begin
      end_of_test();
    end
    rd(card_pkg::OP_SKIP_COL_READY);
    chk1(a.skip, 1'b0);
    chk1(rchk, 1'b0);
  endtask : t_card
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_flags();
    t_hopper();
    t_card(12'h840, 12'h033, 12'hFFF, 12'h043, 12'hFFF);
    t_card(12'h282, 12'h01A, 12'hFFF, 12'h01A, 12'hFFF);
    t_card(12'h111, 12'h000, 12'hFC0, 12'h800, 12'h800);
    end_of_test();
  end
endmodule : tb_card_reader_control
